// ==== bench/central_sequencing_computer_tb_top.sv ====
// Bench for the sequencing computer: memory, checksum, start, modes, events.
// Assumes the partner model makes the wave and logs event pulses.
`timescale 1ns/10ps
`default_nettype none
module central_sequencing_computer_tb_top
   import seq_computer_pkg::*;
();
   // ************************************************************
   // Signals and instances
   // ************************************************************
   localparam int LIMIT = 60000;
   localparam logic [WORD_W-1:0] W1 = 22'h2A5F3C;
   localparam logic [WORD_W-1:0] W2 = 22'h0F00F1;
   logic              ref_clk = 1'b0;
   logic              rst = 1'b1;
   logic              inhibit = 1'b1;
   logic              hold = 1'b1;
   dc_cmd_t           dcmd = '0;
   mem_cmd_t          mcmd = '0;
   logic              load_done = 1'b0;
   logic              check_req = 1'b0;
   logic              read_req = 1'b0;
   logic [ADDR_W-1:0] read_addr = '0;
   event_t            seq_ev = '0;
   event_t            ev_out;
   logic [WORD_W-1:0] rdata;
   logic              sq_wave, rvalid, man, abrt, abrt_l, v_load, ck_done, v_run, run;
   mode_t             mode;
   logic [HOUR_W-1:0] hrs;
   logic [5:0]        mins, secs;
   logic [EVT_W-1:0]  ev_addr;
   int                ev_count;
   int                n_mismatch = 0;
   int                total_checks = 0;
   int                cyc = 0;

   central_sequencing_computer #(.SQ_PER_SEC_P(4)) dut (
      .ref_clk(ref_clk), .rst(rst), .sq_wave(sq_wave), .inhibit(inhibit), .hold(hold),
      .direct_ground_command(dcmd), .coded_memory_command(mcmd), .load_done(load_done),
      .check_req(check_req), .read_req(read_req), .read_addr(read_addr),
      .seq_event(seq_ev), .event_out(ev_out), .read_data(rdata), .read_valid(rvalid),
      .mode(mode), .maneuver_active(man), .abort(abrt), .abort_latched(abrt_l),
      .verify_load(v_load), .check_done(ck_done), .verify_run(v_run), .running(run),
      .elapsed_hours(hrs), .elapsed_minutes(mins), .elapsed_seconds(secs));

   seq_partner_model #(.SQ_HALF(1)) partner (.ref_clk(ref_clk), .event_out(ev_out),
      .sq_wave(sq_wave), .ev_count(ev_count), .ev_addr(ev_addr));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk_bit(string what, logic exp, logic got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_word(string what, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic dc(dc_code_t code);
      @(posedge ref_clk);
      dcmd <= '{valid: 1'b1, code: code};
      @(posedge ref_clk);
      dcmd <= '0;
      #1;
   endtask
   task automatic sev(logic [EVT_W-1:0] a);
      @(posedge ref_clk);
      seq_ev <= '{valid: 1'b1, addr: a};
      @(posedge ref_clk);
      seq_ev <= '0;
      #1;
   endtask
   task automatic store(logic [ADDR_W-1:0] a, logic [WORD_W-1:0] d);
      @(posedge ref_clk);
      mcmd <= '{1'b1, {a, d[21:15]}};
      @(posedge ref_clk);
      mcmd <= '{1'b1, {1'b0, d[14:0]}};
      @(posedge ref_clk);
      mcmd <= '0;
   endtask
   task automatic rd(logic [ADDR_W-1:0] a, logic [WORD_W-1:0] exp);
      @(posedge ref_clk);
      read_req <= 1'b1;
      read_addr <= a;
      @(posedge ref_clk);
      read_req <= 1'b0;
      #1;
      chk_bit("read_valid", 1'b1, rvalid);
      chk_word("read_data", exp, rdata);
   endtask
   function automatic logic pick(int k);
      case (k)
         0: return ck_done;
         1: return abrt;
         2: return run;
         default: return v_run;
      endcase
   endfunction
   task automatic wait_on(int k, int max);
      for (int i = 0; i < max && pick(k) !== 1'b1; i++) tick(1);
      chk_bit("awaited_signal", 1'b1, pick(k));
   endtask
   task automatic checksum(logic exp);
      @(posedge ref_clk);
      check_req <= 1'b1;
      @(posedge ref_clk);
      check_req <= 1'b0;
      wait_on(0, 30000);
      tick(1);
      chk_bit("verify_load", exp, v_load);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_memory();
      for (int a = 0; a < MEM_WORDS - 1; a++) store(a[ADDR_W-1:0], '0);
      store(9'h005, W1);
      store(9'h0C8, W2);
      store(REF_ADDR, W1 + W2);
      rd(9'h005, W1);
      rd(REF_ADDR, W1 + W2);
      rd(9'h006, '0);
      @(posedge ref_clk);
      load_done <= 1'b1;
      @(posedge ref_clk);
      load_done <= 1'b0;
      wait_on(0, 30000);
      tick(1);
      chk_bit("verify_load", 1'b1, v_load);
      store(9'h0C8, W2 + 22'h000001);
      checksum(1'b0);
   endtask
   task automatic t_start();
      chk_bit("running", 1'b0, run);
      @(posedge ref_clk);
      inhibit <= 1'b0;
      wait_on(2, 10);
      chk_word("hours", '0, WORD_W'(hrs));
      chk_word("minutes", '0, WORD_W'(mins));
      chk_bit("verify_run", 1'b0, v_run);
   endtask
   task automatic t_modes();
      dc_code_t cd[3] = '{DC_COMPUTER, DC_SEQUENCER, DC_TANDEM};
      mode_t md[3] = '{MODE_COMPUTER, MODE_SEQUENCER, MODE_TANDEM};
      for (int i = 0; i < 3; i++) begin
         dc(cd[i]);
         chk_word("mode", WORD_W'(md[i]), WORD_W'(mode));
      end
   endtask
   task automatic t_hold();
      int n0;
      dc(DC_SEQUENCER);
      dc(DC_START);
      chk_bit("maneuver", 1'b1, man);
      n0 = ev_count;
      sev(9'h011);
      tick(4);
      chk_word("event_count", WORD_W'(n0), WORD_W'(ev_count));
      @(posedge ref_clk);
      hold <= 1'b0;
      tick(4);
      sev(9'h023);
      tick(2);
      chk_word("event_count", WORD_W'(n0 + 1), WORD_W'(ev_count));
      chk_word("event_addr", 22'h000023, WORD_W'(ev_addr));
      dc(DC_COMPUTER);
      sev(9'h031);
      tick(2);
      chk_word("event_count", WORD_W'(n0 + 1), WORD_W'(ev_count));
      dc(DC_END);
   endtask
   task automatic t_tandem();
      dc(DC_TANDEM);
      dc(DC_START);
      sev(9'h047);
      wait_on(1, 20);
      tick(1);
      chk_word("event_addr", 22'h000047, WORD_W'(ev_addr));
      chk_bit("abort_latched", 1'b1, abrt_l);
      chk_bit("maneuver", 1'b0, man);
      dc(DC_START);
      chk_bit("abort_latched", 1'b0, abrt_l);
      chk_bit("maneuver", 1'b1, man);
      dc(DC_END);
      chk_bit("maneuver", 1'b0, man);
   endtask
   task automatic t_verify_run();
      wait_on(3, 3000);
      chk_word("minutes", 22'h000003, WORD_W'(mins));
      chk_word("seconds", '0, WORD_W'(secs));
      chk_word("hours", '0, WORD_W'(hrs));
   endtask

   // ************************************************************
   // Run control
   // ************************************************************
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         close_out();
      end
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      tick(2);
      chk_word("mode", WORD_W'(MODE_TANDEM), WORD_W'(mode));
      t_memory();
      t_start();
      t_modes();
      t_hold();
      t_tandem();
      t_verify_run();
      close_out();
   end
endmodule
`default_nettype wire

// ==== bench/seq_partner_model.sv ====
// Far-side model: timing square wave source and event actuator log.
// Assumes ref_clk from the bench; the wave is scaled down for short runs.
`timescale 1ns/10ps
`default_nettype none
module seq_partner_model
   import seq_computer_pkg::*;
#(
   parameter int SQ_HALF = 1
) (
   input  wire logic             ref_clk,
   input  wire event_t           event_out,
   output var  logic             sq_wave,
   output var  int               ev_count,
   output var  logic [EVT_W-1:0] ev_addr
);
   // ************************************************************
   // Free-running wave and actuator tally
   // ************************************************************
   int half_cnt;
   initial begin
      sq_wave = 1'b0;
      ev_count = 0;
      ev_addr = '0;
      half_cnt = 0;
   end
   always @(posedge ref_clk) begin
      half_cnt <= (half_cnt == SQ_HALF - 1) ? 0 : half_cnt + 1;
      if (half_cnt == SQ_HALF - 1) begin
         sq_wave <= ~sq_wave;
      end
      if (event_out.valid === 1'b1) begin
         ev_count <= ev_count + 1;
         ev_addr <= event_out.addr;
      end
   end
endmodule
`default_nettype wire

// ==== src/central_sequencing_computer.sv ====
// Central sequencing computer: modes, tandem compare, memory, checksum, time base.
// Assumes command inputs and sequencer events come from logic on ref_clk;
// sq_wave, inhibit and hold are pins and are synchronised here.
//
// Summary of operation
// - Maneuvers run in exactly one mode: tandem, computer alone, sequencer alone.
// - Tandem mode routes fixed sequencer events out; computer only checked.
// - Tandem mismatch between computer and sequencer events aborts the maneuver.
// - Ground direct commands switch mode any time, before or during maneuvers.
// - Program memory holds 512 words of 22 bits.
// - Memory read out or altered one word per operation, any time.
// - After a program change an automatic check can be run on request.
// - After loading, diagnostic sums all program words against stored reference.
// - Zero difference between sum and reference raises the load verify output.
// - Program held until inhibit releases; release starts program and time base.
// - Three minutes after start a second verify output is raised.
// - Time counted in hours, split into minutes and seconds when required.
// - Elapsed time counts from zero at inhibit release.
// - Hold signal blocks all event outputs except verify outputs.
// - Removing hold enables all event outputs.
// - Subtract has compare-and-skip form; an execute-event instruction exists.
// - Checksum arithmetic processed one bit at a time.
// - Clock pulses derived from the square wave time processor, memory, events.
// - Memory store takes two words: address plus top 7 bits, then 15 bits.
`timescale 1ns/10ps
`default_nettype none
module central_sequencing_computer
   import seq_computer_pkg::*;
#(
   parameter int SQ_PER_SEC_P = SQ_PER_SEC
) (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic               sq_wave,
   input  wire logic               inhibit,
   input  wire logic               hold,
   input  wire dc_cmd_t            direct_ground_command,
   input  wire mem_cmd_t           coded_memory_command,
   input  wire logic               load_done,
   input  wire logic               check_req,
   input  wire logic               read_req,
   input  wire logic [ADDR_W-1:0]  read_addr,
   input  wire event_t             seq_event,
   output event_t                  event_out,
   output logic [WORD_W-1:0]       read_data,
   output logic                    read_valid,
   output mode_t                   mode,
   output logic                    maneuver_active,
   output logic                    abort,
   output logic                    abort_latched,
   output logic                    verify_load,
   output logic                    check_done,
   output logic                    verify_run,
   output logic                    running,
   output logic [HOUR_W-1:0]       elapsed_hours,
   output logic [5:0]              elapsed_minutes,
   output logic [5:0]              elapsed_seconds
);
   function automatic logic maj3(input logic a, input logic b, input logic c);
      return (a & b) | (a & c) | (b & c);
   endfunction
   // ************************************************************
   // Pin synchronisers and square wave pulse
   // ************************************************************
   logic [1:0] sq_s_q, inh_s_q, hold_s_q;
   logic       sq_prev_q, inh_prev_q;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {sq_s_q, sq_prev_q}             <= 3'h0;
         {inh_s_q, hold_s_q, inh_prev_q} <= 5'h1F;
      end else begin
         sq_s_q     <= {sq_s_q[0], sq_wave};
         inh_s_q    <= {inh_s_q[0], inhibit};
         hold_s_q   <= {hold_s_q[0], hold};
         sq_prev_q  <= sq_s_q[1];
         inh_prev_q <= inh_s_q[1];
      end
   end
   wire sq_pulse = sq_s_q[1] & ~sq_prev_q;
   wire hold_s   = hold_s_q[1];
   wire release_w = ~inh_s_q[1] & inh_prev_q;
   // ************************************************************
   // Start and time base
   // ************************************************************
   logic                started_q;
   logic [SQ_CNT_W-1:0] sq_cnt_q;
   logic [5:0]          sec_q, min_q;
   logic [HOUR_W-1:0]   hour_q;
   logic                verify_run_q;
   wire sec_tick  = started_q & sq_pulse & (sq_cnt_q == SQ_CNT_W'(SQ_PER_SEC_P - 1));
   wire min_tick  = sec_tick & (sec_q == 6'(SEC_PER_MIN - 1));
   wire hour_tick = min_tick & (min_q == 6'(MIN_PER_HOUR - 1));
   wire run_mark  = started_q & (hour_q == '0) & (min_q == 6'(VERIFY_RUN_MIN));
   always_ff @(posedge ref_clk) begin
      if (rst || inh_s_q[1]) begin
         started_q    <= 1'b0;
         verify_run_q <= 1'b0;
      end else begin
         if (release_w) started_q <= 1'b1;
         if (run_mark) verify_run_q <= 1'b1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst || release_w) begin
         {sq_cnt_q, sec_q, min_q, hour_q} <= '0;
      end else if (started_q && sq_pulse) begin
         sq_cnt_q <= sec_tick ? '0 : sq_cnt_q + 1'b1;
         if (sec_tick) sec_q <= min_tick ? '0 : sec_q + 1'b1;
         if (min_tick) min_q <= hour_tick ? '0 : min_q + 1'b1;
         if (hour_tick) hour_q <= hour_q + 1'b1;
      end
   end
   // ************************************************************
   // Program memory and coded memory commands
   // ************************************************************
   logic [WORD_W-1:0] mem_q [MEM_WORDS];
   logic              second_q;
   logic [ADDR_W-1:0] st_addr_q;
   logic [CMD_TOP_W-1:0] st_top_q;
   wire               cmd_v = coded_memory_command.valid;
   wire [CMD_W-1:0]   cmd_w = coded_memory_command.word;
   wire               wr_en = cmd_v & second_q;
   wire [WORD_W-1:0]  wr_data = {st_top_q, cmd_w[CMD_LOW_W-1:0]};
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {second_q, st_addr_q, st_top_q} <= '0;
      end else if (cmd_v) begin
         second_q <= ~second_q;
         if (!second_q) begin
            st_addr_q <= cmd_w[CMD_ADDR_HI:CMD_ADDR_LO];
            st_top_q  <= cmd_w[CMD_TOP_W-1:0];
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (wr_en) mem_q[st_addr_q] <= wr_data;
   end
   logic [WORD_W-1:0] read_data_q;
   logic              read_valid_q;
   wire [WORD_W-1:0]  rd_word = mem_q[read_addr];
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {read_data_q, read_valid_q} <= '0;
      end else begin
         read_valid_q <= read_req;
         if (read_req) read_data_q <= rd_word;
      end
   end
   // ************************************************************
   // Bit-serial checksum diagnostic
   // ************************************************************
   ck_state_t            ck_state_q;
   logic [WORD_W-1:0]    acc_q;
   logic                 carry_q, verify_load_q, check_done_q;
   logic [BIT_IDX_W-1:0] ck_bit_q;
   logic [ADDR_W-1:0]    ck_word_q;
   wire [WORD_W-1:0] ck_in   = mem_q[ck_word_q];
   wire              in_bit  = ck_in[ck_bit_q];
   wire              acc_bit = acc_q[ck_bit_q];
   wire              last_bit = (ck_bit_q == BIT_IDX_W'(WORD_W - 1));
   wire [WORD_W-1:0] ck_diff = acc_q - mem_q[REF_ADDR];
   wire              diff_zero = (ck_diff == '0);
   wire              ck_start = (load_done | check_req) & (ck_state_q == CK_IDLE);
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ck_state_q <= CK_IDLE;
         {acc_q, carry_q, ck_bit_q, ck_word_q, verify_load_q, check_done_q} <= '0;
      end else begin
         check_done_q <= 1'b0;
         case (ck_state_q)
            CK_IDLE: begin
               if (ck_start) begin
                  {acc_q, carry_q, ck_bit_q, ck_word_q, verify_load_q} <= '0;
                  ck_state_q <= CK_ADD;
               end
            end
            CK_ADD: begin
               if (sq_pulse) begin
                  acc_q[ck_bit_q] <= acc_bit ^ in_bit ^ carry_q;
                  carry_q  <= last_bit ? 1'b0 : maj3(acc_bit, in_bit, carry_q);
                  ck_bit_q <= last_bit ? '0 : ck_bit_q + 1'b1;
                  if (last_bit) begin
                     ck_word_q <= ck_word_q + 1'b1;
                     if (ck_word_q == REF_ADDR - 1'b1) ck_state_q <= CK_CMP;
                  end
               end
            end
            CK_CMP: begin
               verify_load_q <= diff_zero;
               check_done_q  <= 1'b1;
               ck_state_q    <= CK_IDLE;
            end
            default: ck_state_q <= CK_IDLE;
         endcase
      end
   end
   // ************************************************************
   // Program processor, one instruction per clock pulse
   // ************************************************************
   logic [ADDR_W-1:0] pc_q;
   logic [WORD_W-1:0] cpu_acc_q;
   logic              scan_q, fine_sec_q, fine_min_q;
   event_t            cpu_evt_q;
   wire [WORD_W-1:0]  instr   = mem_q[pc_q];
   wire opcode_t      opc     = opcode_t'(instr[OPC_HI:OPC_LO]);
   wire [ADDR_W-1:0]  operand = instr[OPND_HI:0];
   wire [WORD_W-1:0]  opnd_w  = mem_q[operand];
   wire [WORD_W-1:0]  sub_res = cpu_acc_q - opnd_w;
   wire scan_go = hour_tick | (fine_sec_q & sec_tick) | (fine_min_q & min_tick);
   wire step    = scan_q & sq_pulse & (ck_state_q == CK_IDLE);
   always_ff @(posedge ref_clk) begin
      if (rst || !started_q) begin
         {pc_q, cpu_acc_q, scan_q, fine_sec_q, fine_min_q, cpu_evt_q} <= '0;
      end else begin
         cpu_evt_q <= '0;
         if (scan_go && !scan_q) begin
            scan_q     <= 1'b1;
            pc_q       <= '0;
            fine_sec_q <= 1'b0;
            fine_min_q <= 1'b0;
         end else if (step) begin
            pc_q <= pc_q + 1'b1;
            case (opc)
               OP_HALT:     scan_q <= 1'b0;
               OP_ADD:      cpu_acc_q <= cpu_acc_q + opnd_w;
               OP_SUB:      cpu_acc_q <= sub_res;
               OP_SUB_SKIP: if (sub_res == '0) pc_q <= pc_q + 2'd2;
               OP_JUMP:     pc_q <= operand;
               OP_EVENT:    cpu_evt_q <= '{valid: 1'b1, addr: operand};
               OP_FINE_SEC: fine_sec_q <= 1'b1;
               OP_FINE_MIN: fine_min_q <= 1'b1;
               default:     scan_q <= 1'b0;
            endcase
         end
      end
   end
   // ************************************************************
   // Modes, maneuver, tandem compare
   // ************************************************************
   mode_t  mode_q;
   logic   man_q, abort_q, supp_q;
   event_t cpu_win_q, seq_win_q;
   wire dc_v = direct_ground_command.valid;
   wire dc_code_t dc_c = direct_ground_command.code;
   wire mismatch = (cpu_win_q != seq_win_q);
   wire trip = man_q & (mode_q == MODE_TANDEM) & sq_pulse & mismatch;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mode_q <= MODE_TANDEM;
         {man_q, abort_q, supp_q} <= '0;
      end else begin
         abort_q <= trip;
         if (dc_v) begin
            case (dc_c)
               DC_TANDEM:    mode_q <= MODE_TANDEM;
               DC_COMPUTER:  mode_q <= MODE_COMPUTER;
               DC_SEQUENCER: mode_q <= MODE_SEQUENCER;
               default:      mode_q <= mode_q;
            endcase
         end
         if (trip) begin
            man_q  <= 1'b0;
            supp_q <= 1'b1;
         end else if (dc_v && dc_c == DC_START) begin
            man_q  <= 1'b1;
            supp_q <= 1'b0;
         end else if (dc_v && dc_c == DC_END) begin
            man_q <= 1'b0;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst || !man_q) begin
         {cpu_win_q, seq_win_q} <= '0;
      end else if (sq_pulse) begin
         cpu_win_q <= cpu_evt_q;
         seq_win_q <= seq_event;
      end else begin
         if (cpu_evt_q.valid) cpu_win_q <= cpu_evt_q;
         if (seq_event.valid) seq_win_q <= seq_event;
      end
   end
   // ************************************************************
   // Event output selection and gating
   // ************************************************************
   event_t evt_q;
   wire event_t man_src = (mode_q == MODE_COMPUTER) ? cpu_evt_q : seq_event;
   wire event_t sel_evt = man_q ? man_src : (supp_q ? '0 : cpu_evt_q);
   wire         gate_ok = started_q & ~hold_s;
   always_ff @(posedge ref_clk) begin
      if (rst) evt_q <= '0;
      else     evt_q <= gate_ok ? sel_evt : '0;
   end
   assign event_out       = evt_q;
   assign read_data       = read_data_q;
   assign read_valid      = read_valid_q;
   assign mode            = mode_q;
   assign maneuver_active = man_q;
   assign abort           = abort_q;
   assign abort_latched   = supp_q;
   assign verify_load     = verify_load_q;
   assign check_done      = check_done_q;
   assign verify_run      = verify_run_q;
   assign running         = started_q;
   assign elapsed_hours   = hour_q;
   assign elapsed_minutes = min_q;
   assign elapsed_seconds = sec_q;
   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_hold_block;
      hold_s |=> !event_out.valid;
   endproperty
   a_hold_block: assert property (p_hold_block) else $error("event passed hold");
   property p_released;
      gate_ok && man_q && mode_q == MODE_SEQUENCER && seq_event.valid
         |=> event_out.valid && event_out.addr == $past(seq_event.addr);
   endproperty
   a_released: assert property (p_released) else $error("event lost without hold");
   property p_tandem_src;
      gate_ok && man_q && mode_q == MODE_TANDEM |=> event_out == $past(seq_event);
   endproperty
   a_tandem_src: assert property (p_tandem_src) else $error("tandem source wrong");
   sequence s_trip;
      man_q && mode_q == MODE_TANDEM && sq_pulse && mismatch;
   endsequence
   property p_abort;
      s_trip |=> abort && !maneuver_active && abort_latched;
   endproperty
   a_abort: assert property (p_abort) else $error("mismatch did not abort");
   property p_mode;
      dc_v && dc_c == DC_COMPUTER |=> mode == MODE_COMPUTER;
   endproperty
   a_mode: assert property (p_mode) else $error("mode command ignored");
   sequence s_store;
      cmd_v && !second_q ##1 cmd_v [*1];
   endsequence
   property p_store;
      s_store |=> mem_q[$past(st_addr_q)] == $past(wr_data);
   endproperty
   a_store: assert property (p_store) else $error("two word store failed");
   property p_read;
      read_req |=> read_valid && read_data == $past(rd_word);
   endproperty
   a_read: assert property (p_read) else $error("readout wrong");
   property p_run;
      run_mark |=> verify_run;
   endproperty
   a_run: assert property (p_run) else $error("run verify missing");
   property p_zero;
      release_w |=> hour_q == '0 && min_q == '0 && sec_q == '0 && started_q;
   endproperty
   a_zero: assert property (p_zero) else $error("time not zeroed at start");
   property p_check;
      ck_state_q == CK_CMP |=> check_done && verify_load == $past(diff_zero);
   endproperty
   a_check: assert property (p_check) else $error("checksum verdict wrong");
endmodule
`default_nettype wire

// ==== src/seq_computer_pkg.sv ====
// Constants, encodings and carriers for the central sequencing computer.
// Assumes a single 25 MHz reference clock and a 2.4 kHz timing square wave.
package seq_computer_pkg;

   // ************************************************************
   // Widths and memory
   // ************************************************************
   localparam int WORD_W    = 22;
   localparam int ADDR_W    = 9;
   localparam int MEM_WORDS = 512;
   localparam int EVT_W     = 9;
   localparam int BIT_IDX_W = 5;
   localparam logic [ADDR_W-1:0] REF_ADDR = 9'h1FF;

   // ************************************************************
   // Instruction and command word fields
   // ************************************************************
   localparam int OPC_HI      = 21;
   localparam int OPC_LO      = 19;
   localparam int OPND_HI     = 8;
   localparam int CMD_W       = 16;
   localparam int CMD_ADDR_HI = 15;
   localparam int CMD_ADDR_LO = 7;
   localparam int CMD_TOP_W   = 7;
   localparam int CMD_LOW_W   = 15;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_FREQ_HZ    = 25000000;
   localparam int SQ_FREQ_HZ     = 2400;
   localparam int SQ_PER_SEC     = SQ_FREQ_HZ * 1;
   localparam int SEC_PER_MIN    = 60;
   localparam int MIN_PER_HOUR   = 60;
   localparam int VERIFY_RUN_MIN = 3;
   localparam int SQ_CNT_W       = 12;
   localparam int HOUR_W         = 16;

   // ************************************************************
   // Enumerations and carriers
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_TANDEM    = 2'b00,
      MODE_COMPUTER  = 2'b01,
      MODE_SEQUENCER = 2'b10
   } mode_t;

   typedef enum logic [2:0] {
      DC_NONE      = 3'b000,
      DC_TANDEM    = 3'b001,
      DC_COMPUTER  = 3'b010,
      DC_SEQUENCER = 3'b011,
      DC_START     = 3'b100,
      DC_END       = 3'b101
   } dc_code_t;

   typedef enum logic [2:0] {
      OP_HALT     = 3'b000,
      OP_ADD      = 3'b001,
      OP_SUB      = 3'b010,
      OP_SUB_SKIP = 3'b011,
      OP_JUMP     = 3'b100,
      OP_EVENT    = 3'b101,
      OP_FINE_SEC = 3'b110,
      OP_FINE_MIN = 3'b111
   } opcode_t;

   typedef enum logic [1:0] {
      CK_IDLE = 2'b00,
      CK_ADD  = 2'b01,
      CK_CMP  = 2'b10
   } ck_state_t;

   typedef struct packed {
      logic     valid;
      dc_code_t code;
   } dc_cmd_t;

   typedef struct packed {
      logic             valid;
      logic [CMD_W-1:0] word;
   } mem_cmd_t;

   typedef struct packed {
      logic             valid;
      logic [EVT_W-1:0] addr;
   } event_t;

endpackage
